/* File: design/ufw_ctrl.v */
// Mode register zero: FIFO thresholds, depth select and receiver idle watchdog
`default_nettype none
`include "ufw_consts.vh"

module ufw_ctrl #(
	parameter IDLE_BITS = `UFW_IDLE_BIT_TIMES
) (
	// Clock and reset
	input wire clk,
	input wire reset,
	// Register port
	input wire [3:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	output reg [7:0] reg_rdata,
	// Channel command: pointer commands; only the channel A strobe is decoded, cmd_write_b is unused
	input wire [3:0] cmd_code,
	input wire cmd_write_a,
	input wire cmd_write_b,
	// Mode register one receiver threshold bits
	input wire mode_one_rx_a,
	input wire mode_one_rx_b,
	// Receiver 1x clock pin
	input wire rx_clk_pin,
	// Channel A FIFO state
	input wire [4:0] rx_count_a,
	input wire [4:0] tx_count_a,
	input wire rx_access_a,
	input wire tx_write_a,
	input wire tx_enabled_a,
	// Channel B FIFO state
	input wire [4:0] rx_count_b,
	input wire [4:0] tx_count_b,
	input wire rx_access_b,
	input wire tx_write_b,
	input wire tx_enabled_b,
	// Configuration out
	output wire queue_depth_select,
	output wire rate_group_select_low,
	output wire rate_group_select_high,
	output wire factory_test_bit,
	// Requests and status, per channel
	output reg rx_fill_request_a,
	output reg tx_space_request_a,
	output reg rx_char_available_a,
	output reg rx_fill_request_b,
	output reg tx_space_request_b,
	output reg rx_char_available_b,
	output reg [7:0] channel_status_reg_a,
	output reg [7:0] channel_status_reg_b
);

	// ****************************************
	// Decoding functions
	// ****************************************
	// Byte count of the selected FIFO depth, shared by every level decode
	function [4:0] depth_of;
		input deep;
		begin
			if (deep)
				depth_of = `UFW_DEPTH_LARGE;
			else
				depth_of = `UFW_DEPTH_SMALL;
		end
	endfunction

	// Receiver request: filled places against the level picked by the code
	function rx_hit;
		input [1:0] code;
		input deep;
		input [4:0] cnt;
		reg [4:0] level;
		begin
			level = 5'd1;
			if (deep) begin
				case (code)
					2'b00: level = 5'd1;
					2'b01: level = 5'd8;
					2'b10: level = 5'd12;
					default: level = depth_of(1'b1);
				endcase
			end else begin
				case (code)
					2'b00: level = 5'd1;
					2'b01: level = 5'd3;
					2'b10: level = 5'd6;
					default: level = depth_of(1'b0);
				endcase
			end
			rx_hit = (cnt >= level);
		end
	endfunction

	// Transmitter request: empty places against the level picked by the code
	function tx_hit;
		input [1:0] code;
		input deep;
		input [4:0] used;
		reg [4:0] depth;
		reg [4:0] room;
		reg [4:0] level;
		begin
			depth = depth_of(deep);
			// A count above the depth, left over from a depth change, reads as
			// no room instead of wrapping round to a large value
			if (used >= depth)
				room = 5'd0;
			else
				room = depth - used;
			level = 5'd1;
			if (deep) begin
				case (code)
					2'b00: level = depth;
					2'b01: level = 5'd8;
					2'b10: level = 5'd12;
					default: level = 5'd1;
				endcase
			end else begin
				case (code)
					2'b00: level = depth;
					2'b01: level = 5'd4;
					2'b10: level = 5'd6;
					default: level = 5'd1;
				endcase
			end
			tx_hit = (room >= level);
		end
	endfunction

	// ****************************************
	// Mode register zero and pointer
	// ****************************************
	reg [7:0] mode_reg_zero;
	reg ptr_zero_a;
	wire sel_zero = reg_addr == `UFW_MODE_ZERO_OFFSET;

	// Pointer clears after any mode access, as the pointer walks onward
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			ptr_zero_a <= 1'b0;
		end else if (cmd_write_a && cmd_code == `UFW_PTR_CMD_ZERO) begin
			ptr_zero_a <= 1'b1;
		end else if (cmd_write_a && cmd_code == `UFW_PTR_CMD) begin
			ptr_zero_a <= 1'b0;
		end else if (sel_zero && (reg_write || reg_read)) begin
			ptr_zero_a <= 1'b0;
		end
	end

	// A write with the pointer elsewhere is dropped without notice
	always @(posedge clk or posedge reset) begin
		if (reset)
			mode_reg_zero <= `UFW_MODE_ZERO_RESET;
		else if (sel_zero && reg_write && ptr_zero_a)
			mode_reg_zero <= reg_wdata;
	end

	always @(posedge clk or posedge reset) begin
		if (reset)
			reg_rdata <= 8'h00;
		else if (sel_zero && reg_read && ptr_zero_a)
			reg_rdata <= mode_reg_zero;
		else if (reg_read)
			reg_rdata <= 8'h00;
	end

	wire idle_enable = mode_reg_zero[`UFW_BIT_IDLE_ALARM];
	assign queue_depth_select = mode_reg_zero[`UFW_BIT_DEPTH_SEL];
	assign rate_group_select_low = mode_reg_zero[`UFW_BIT_RATE_LO];
	assign rate_group_select_high = mode_reg_zero[`UFW_BIT_RATE_HI];
	assign factory_test_bit = mode_reg_zero[`UFW_BIT_TEST];

	// ****************************************
	// Receiver 1x clock edge detection
	// ****************************************
	reg [2:0] rx_clk_sync;
	always @(posedge clk or posedge reset) begin
		if (reset)
			rx_clk_sync <= 3'b000;
		else
			rx_clk_sync <= {rx_clk_sync[1:0], rx_clk_pin};
	end
	wire bit_tick = rx_clk_sync[1] & ~rx_clk_sync[2];

	// ****************************************
	// Per-channel threshold and watchdog logic
	// ****************************************
	wire [1:0] rx_code_live [0:1];
	wire [1:0] tx_code_live = mode_reg_zero[`UFW_BIT_TX_THR_HI:`UFW_BIT_TX_THR_LO];
	assign rx_code_live[0] = {mode_reg_zero[`UFW_BIT_RX_THR_HI], mode_one_rx_a};
	assign rx_code_live[1] = {mode_reg_zero[`UFW_BIT_RX_THR_HI], mode_one_rx_b};

	wire [4:0] rxc [0:1];
	wire [4:0] txc [0:1];
	wire [1:0] rx_acc = {rx_access_b, rx_access_a};
	wire [1:0] tx_wr = {tx_write_b, tx_write_a};
	wire [1:0] tx_en = {tx_enabled_b, tx_enabled_a};
	assign rxc[0] = rx_count_a;
	assign rxc[1] = rx_count_b;
	assign txc[0] = tx_count_a;
	assign txc[1] = tx_count_b;

	wire [1:0] rx_req;
	wire [1:0] tx_req;
	wire [1:0] rx_avail;
	wire [1:0] rx_full;
	wire [1:0] tx_empty;
	wire [1:0] tx_room;

	// The idle counter is 7 bits wide: IDLE_BITS above 128 would wrap
	localparam [6:0] IDLE_LAST = IDLE_BITS[6:0] - 7'd1;

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
			reg [1:0] rx_code;
			reg [1:0] tx_code;
			reg [6:0] idle_count;
			reg idle_alarm;
			wire fifo_touch = rx_acc[ch] | tx_wr[ch];
			wire both_empty = (rxc[ch] == 5'd0) && (txc[ch] == 5'd0);

			// Latched codes follow live bits only when safe, so a mid-stream
			// change cannot make a request glitch
			always @(posedge clk or posedge reset) begin
				if (reset) begin
					rx_code <= 2'b00;
					tx_code <= 2'b00;
				end else if (both_empty || fifo_touch) begin
					rx_code <= rx_code_live[ch];
					tx_code <= tx_code_live;
				end
			end

			always @(posedge clk or posedge reset) begin
				if (reset) begin
					idle_count <= 7'd0;
					idle_alarm <= 1'b0;
				end else if (!idle_enable || rx_acc[ch] || rxc[ch] == 5'd0) begin
					idle_count <= 7'd0;
					idle_alarm <= 1'b0;
				end else if (bit_tick) begin
					if (idle_count == IDLE_LAST)
						idle_alarm <= 1'b1;
					else
						idle_count <= idle_count + 7'd1;
				end
			end

			assign rx_req[ch] = rx_hit(rx_code, queue_depth_select, rxc[ch]) | idle_alarm;
			assign tx_req[ch] = tx_en[ch] & tx_hit(tx_code, queue_depth_select, txc[ch]);
			assign rx_avail[ch] = (rxc[ch] != 5'd0) | idle_alarm;
			assign rx_full[ch] = rxc[ch] >= depth_of(queue_depth_select);
			assign tx_empty[ch] = txc[ch] == 5'd0;
			assign tx_room[ch] = tx_en[ch] & tx_hit(2'b11, queue_depth_select, txc[ch]);
		end
	endgenerate

	// ****************************************
	// Registered outputs
	// ****************************************
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			rx_fill_request_a <= 1'b0;
			tx_space_request_a <= 1'b0;
			rx_char_available_a <= 1'b0;
			channel_status_reg_a <= 8'h00;
		end else begin
			rx_fill_request_a <= rx_req[0];
			tx_space_request_a <= tx_req[0];
			rx_char_available_a <= rx_avail[0];
			channel_status_reg_a <= {4'h0, tx_empty[0], tx_room[0], rx_full[0], rx_avail[0]};
		end
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			rx_fill_request_b <= 1'b0;
			tx_space_request_b <= 1'b0;
			rx_char_available_b <= 1'b0;
			channel_status_reg_b <= 8'h00;
		end else begin
			rx_fill_request_b <= rx_req[1];
			tx_space_request_b <= tx_req[1];
			rx_char_available_b <= rx_avail[1];
			channel_status_reg_b <= {4'h0, tx_empty[1], tx_room[1], rx_full[1], rx_avail[1]};
		end
	end

endmodule // ufw_ctrl
`default_nettype wire

/* File: pkg/ufw_consts.vh */
// Constants for the mode register zero FIFO level and watchdog block
`ifndef UFW_CONSTS_VH
`define UFW_CONSTS_VH

`define UFW_MODE_ZERO_OFFSET 4'h0
`define UFW_MODE_ZERO_RESET 8'h00
`define UFW_BIT_IDLE_ALARM 7
`define UFW_BIT_RX_THR_HI 6
`define UFW_BIT_TX_THR_HI 5
`define UFW_BIT_TX_THR_LO 4
`define UFW_BIT_DEPTH_SEL 3
`define UFW_BIT_RATE_HI 2
`define UFW_BIT_TEST 1
`define UFW_BIT_RATE_LO 0
`define UFW_BIT_MODE_ONE_RX_THR 6
`define UFW_IDLE_BIT_TIMES 7'd64
`define UFW_DEPTH_SMALL 5'd8
`define UFW_DEPTH_LARGE 5'd16
`define UFW_PTR_CMD 4'h1
`define UFW_PTR_CMD_ZERO 4'hb

`endif

/* File: dv/ufw_asserts.sv */
// Port checker for the mode register zero threshold block
`default_nettype none
module ufw_asserts (
	// Watched ports
	input wire logic clk,
	input wire logic reset,
	input wire logic reg_write,
	input wire logic [4:0] rx_count_a,
	input wire logic [4:0] tx_count_a,
	input wire logic tx_enabled_a,
	input wire logic queue_depth_select,
	input wire logic rx_fill_request_a,
	input wire logic tx_space_request_a,
	input wire logic rx_char_available_a,
	input wire logic [7:0] channel_status_reg_a
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk);
	endclocking
	default disable iff (reset);
	// Three empty cycles so a pending idle alarm has cleared too
	sequence s_rx_empty;
		rx_count_a == 5'h0 [*3];
	endsequence
	sequence s_deep_full;
		(queue_depth_select && rx_count_a == 5'h10) [*2];
	endsequence
	property p_rx_empty; s_rx_empty |-> !rx_fill_request_a; endproperty
	a_rx_empty: assert property (p_rx_empty) else $error("rx request when empty");
	property p_deep_full; s_deep_full |-> rx_fill_request_a; endproperty
	a_deep_full: assert property (p_deep_full) else $error("no rx request at 16");
	property p_small_full; (!queue_depth_select && rx_count_a >= 5'h8) [*2] |-> rx_fill_request_a;
	endproperty
	a_small_full: assert property (p_small_full) else $error("no rx request at 8");
	property p_tx_idle; (tx_enabled_a && tx_count_a == 5'h0) [*2] |-> tx_space_request_a;
	endproperty
	a_tx_idle: assert property (p_tx_idle) else $error("no tx request when empty");
	property p_tx_off; !tx_enabled_a |=> !tx_space_request_a; endproperty
	a_tx_off: assert property (p_tx_off) else $error("tx request while disabled");
	property p_tx_full; tx_count_a == 5'h10 |=> !tx_space_request_a; endproperty
	a_tx_full: assert property (p_tx_full) else $error("tx request when full");
	property p_status; rx_fill_request_a |-> rx_char_available_a && channel_status_reg_a[0];
	endproperty
	a_status: assert property (p_status) else $error("status bit differs");
	property p_depth_hold; !$past(reg_write) |-> $stable(queue_depth_select); endproperty
	a_depth_hold: assert property (p_depth_hold) else $error("depth moved alone");
endmodule // ufw_asserts
`default_nettype wire

/* File: dv/ufw_bitclk.sv */
// Receiver 1x bit clock source, still between bursts
`default_nettype none
module ufw_bitclk (
	// Clock and control
	input wire logic clk,
	input wire logic run,
	// Bit clock
	output logic rx_clk_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] div = 3'h0;
	always @(posedge clk) begin
		div <= run ? div + 3'h1 : 3'h0;
	end
	assign rx_clk_pin = div[2];
endmodule // ufw_bitclk
`default_nettype wire

/* File: dv/ufw_ctrl_test.sv */
// Self-checking testbench for the mode register zero threshold block
`default_nettype none
`include "ufw_consts.vh"
module ufw_ctrl_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, reset = 1'b1, cmd_write_a = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
	logic mode_one = 1'b0, acc = 1'b0, twr = 1'b0, tx_en = 1'b0, run = 1'b0;
	logic [3:0] cmd_code = 4'h0, reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00, d;
	logic [4:0] rxn = 5'h0, txn = 5'h0;
	logic [4:0] rt [8] = '{5'h1, 5'h3, 5'h6, 5'h8, 5'h1, 5'h8, 5'hc, 5'h10};
	logic [4:0] tt [8] = '{5'h8, 5'h4, 5'h6, 5'h1, 5'h10, 5'h8, 5'hc, 5'h1};
	logic [7:0] rg [3] = '{8'h00, 8'hb1, 8'h4c};
	logic [2:0] want;
	wire rx_clk_pin, depth, lo, hi, rx_req, tx_req, rx_av;
	wire tb, rx_req_b, tx_req_b, rx_av_b;
	wire [7:0] reg_rdata, st_a, st_b;
	int errors = 0, num_checks = 0, dep;
	ufw_bitclk i_ufw_bitclk (.clk(clk), .run(run), .rx_clk_pin(rx_clk_pin));
	ufw_ctrl #(.IDLE_BITS(4)) i_ufw_ctrl (.clk(clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.cmd_code(cmd_code), .cmd_write_a(cmd_write_a), .cmd_write_b(1'b0),
		.mode_one_rx_a(mode_one), .mode_one_rx_b(mode_one), .rx_clk_pin(rx_clk_pin),
		.rx_count_a(rxn), .tx_count_a(txn), .rx_access_a(acc), .tx_write_a(twr), .tx_enabled_a(tx_en),
		.rx_count_b(rxn), .tx_count_b(txn), .rx_access_b(acc), .tx_write_b(twr), .tx_enabled_b(tx_en),
		.queue_depth_select(depth), .rate_group_select_low(lo), .rate_group_select_high(hi),
		.factory_test_bit(tb), .rx_fill_request_a(rx_req), .tx_space_request_a(tx_req),
		.rx_char_available_a(rx_av), .rx_fill_request_b(rx_req_b),
		.tx_space_request_b(tx_req_b), .rx_char_available_b(rx_av_b),
		.channel_status_reg_a(st_a), .channel_status_reg_b(st_b));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Pointer command first, then one access, as the register port demands
	task automatic acc_reg(input logic wr, input logic [3:0] a, input logic [7:0] v);
		cmd_code <= `UFW_PTR_CMD_ZERO;
		cmd_write_a <= 1'b1;
		@(posedge clk);
		cmd_write_a <= 1'b0;
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= wr;
		reg_read <= !wr;
		@(posedge clk);
		reg_write <= 1'b0;
		reg_read <= 1'b0;
		@(posedge clk);
		d = reg_rdata;
	endtask
	// One-cycle strobe: 0 register write, 1 tx load, 2 rx read
	task automatic pulse_wait(input int which);
		reg_write <= (which == 0);
		twr <= (which == 1);
		acc <= (which == 2);
		@(posedge clk);
		reg_write <= 1'b0;
		twr <= 1'b0;
		acc <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		end_sim;
	end
	initial begin
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		tx_en <= 1'b1;
		@(posedge clk);
		acc_reg(1'b0, 4'h0, 8'h00);
		chk(d, `UFW_MODE_ZERO_RESET, "mode reset value");
		acc_reg(1'b0, 4'h1, 8'h00);
		chk(d, 8'h00, "unmapped read");
		foreach (rg[i]) begin
			acc_reg(1'b1, 4'h0, rg[i]);
			acc_reg(1'b0, 4'h0, 8'h00);
			chk(d, rg[i], "mode readback");
			chk(8'({hi, depth, lo}), 8'({rg[i][2], rg[i][3], rg[i][0]}), "rate and depth");
			chk(8'(tb), 8'(rg[i][1]), "test bit");
		end
		reg_wdata <= 8'hff;
		pulse_wait(0);
		acc_reg(1'b0, 4'h0, 8'h00);
		chk(d, rg[2], "write without pointer");
		// Code k[1:0] serves both directions, k[2] is the depth
		for (int k = 0; k < 8; k++) begin
			rxn <= 5'h0;
			txn <= 5'h0;
			mode_one <= k[0];
			acc_reg(1'b1, 4'h0, {1'b0, k[1], k[1:0], k[2], 3'h0});
			dep = k[2] ? 16 : 8;
			for (int n = 0; n <= dep; n++) begin
				rxn <= 5'(n);
				txn <= 5'(n);
				repeat (2) @(posedge clk);
				chk(8'(rx_req), 8'(n >= rt[k]), "rx request");
				chk(8'(tx_req), 8'((dep - n) >= tt[k]), "tx request");
				chk(8'(rx_av), 8'(n != 0), "rx available");
				want = {n >= rt[k], (dep - n) >= tt[k], n != 0};
				chk(8'({rx_req_b, tx_req_b, rx_av_b}), 8'(want), "channel b requests");
				chk(st_a, 8'({n == 0, n < dep, n >= dep, n != 0}), "channel a status");
				chk(st_b, 8'({n == 0, n < dep, n >= dep, n != 0}), "channel b status");
			end
		end
		rxn <= 5'h0;
		txn <= 5'h0;
		mode_one <= 1'b0;
		acc_reg(1'b1, 4'h0, 8'h00);
		tx_en <= 1'b0;
		repeat (2) @(posedge clk);
		chk(8'(tx_req), 8'h00, "tx disabled");
		tx_en <= 1'b1;
		repeat (2) @(posedge clk);
		chk(8'(tx_req), 8'h01, "tx enabled empty");
		txn <= 5'h1;
		pulse_wait(1);
		chk(8'(tx_req), 8'h00, "tx one loaded");
		rxn <= 5'h5;
		mode_one <= 1'b1;
		acc_reg(1'b1, 4'h0, 8'h40);
		repeat (2) @(posedge clk);
		chk(8'(rx_req), 8'h01, "old code kept");
		pulse_wait(2);
		chk(8'(rx_req), 8'h00, "new code applied");
		for (int en = 0; en < 2; en++) begin
			rxn <= 5'h0;
			txn <= 5'h0;
			acc_reg(1'b1, 4'h0, {en[0], 7'h48});
			rxn <= 5'h1;
			run <= 1'b1;
			// Three bit clock edges counted by now, one short of the limit of four
			repeat (24) @(posedge clk);
			chk(8'(rx_req), 8'h00, "idle alarm early");
			repeat (76) @(posedge clk);
			chk(8'(rx_req), 8'(en), "idle alarm");
			// One byte held keeps the flag up, alarm or not
			chk(8'(st_a[0]), 8'h01, "idle alarm status");
			run <= 1'b0;
			pulse_wait(2);
			chk(8'(rx_req), 8'h00, "alarm cleared");
		end
		end_sim;
	end
endmodule // ufw_ctrl_test
bind ufw_ctrl ufw_asserts i_ufw_asserts (.clk(clk), .reset(reset), .reg_write(reg_write),
	.rx_count_a(rx_count_a), .tx_count_a(tx_count_a), .tx_enabled_a(tx_enabled_a),
	.queue_depth_select(queue_depth_select), .rx_fill_request_a(rx_fill_request_a),
	.tx_space_request_a(tx_space_request_a), .rx_char_available_a(rx_char_available_a),
	.channel_status_reg_a(channel_status_reg_a));
`default_nettype wire
